// *** design/mnp_pkg.sv ***
/*
  Constants shared by the melody note player: register offsets, reset
  values, bus address, timing counts and the scale divisor table.
  Assumes a 250 MHz system clock.
*/
package mnp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_CONFIG        = 8'h00;
  localparam logic [7:0] OFF_MELODY        = 8'hF0;
  localparam logic [7:0] OFF_TONE_PIN_LO   = 8'hF8;
  localparam logic [7:0] OFF_TONE_PIN_HI   = 8'hF9;
  localparam logic [7:0] OFF_TONE_POW_LO   = 8'hFA;
  localparam logic [7:0] OFF_TONE_POW_HI   = 8'hFB;
  localparam logic [7:0] OFF_IRQ_PIN_LO    = 8'hFC;
  localparam logic [7:0] OFF_IRQ_PIN_HI    = 8'hFD;

  // Field positions and reset values
  localparam int         SHUTDOWN_BIT      = 0;
  localparam logic [7:0] RST_CONFIG        = 8'h00;
  localparam logic [7:0] RST_TONE_PIN_LO   = 8'h04;
  localparam logic       RST_TONE_PIN_HI   = 1'b0;
  localparam logic [7:0] RST_TONE_POW_LO   = 8'h00;
  localparam logic       RST_TONE_POW_HI   = 1'b1;
  localparam logic [7:0] RST_IRQ_PIN_LO    = 8'h00;
  localparam logic       RST_IRQ_PIN_HI    = 1'b0;

  // ****************************************************************
  // Serial bus and melody command
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR          = 7'h3C;   // 0x78 write, 0x79 read
  localparam logic [7:0] MELODY_CLEAR      = 8'hFF;
  localparam int         NOTE_BYTES        = 4;
  localparam int         NOTE_SLOTS        = 10;
  localparam int         SCALE_COUNT       = 60;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_HZ            = 250_000_000;
  localparam int         UNIT_MS           = 4;
  localparam int         UNIT_CYCLES       = CLK_HZ / 1000 * UNIT_MS;
  localparam int         TONE_CLK_HZ       = 500_000;
  localparam int         TONE_PRE_CYCLES   = CLK_HZ / TONE_CLK_HZ;

  // Tone clock divisor per scale index, lowest note first
  localparam logic [11:0] SCALE_DIV [SCALE_COUNT] = '{
    12'd2273, 12'd2145, 12'd2025, 12'd1911, 12'd1804, 12'd1703,
    12'd1607, 12'd1517, 12'd1432, 12'd1351, 12'd1276, 12'd1204,
    12'd1136, 12'd1073, 12'd1012, 12'd956,  12'd902,  12'd851,
    12'd804,  12'd758,  12'd716,  12'd676,  12'd638,  12'd602,
    12'd568,  12'd536,  12'd506,  12'd478,  12'd451,  12'd426,
    12'd402,  12'd379,  12'd358,  12'd338,  12'd319,  12'd301,
    12'd284,  12'd268,  12'd253,  12'd239,  12'd225,  12'd213,
    12'd201,  12'd190,  12'd179,  12'd169,  12'd159,  12'd150,
    12'd142,  12'd134,  12'd127,  12'd119,  12'd113,  12'd106,
    12'd100,  12'd95,   12'd89,   12'd84,   12'd80,   12'd75
  };

  // Serial slave and player states
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_WR   = 2'b10,
    BUS_RD   = 2'b11
  } mnp_bus_e;

  typedef enum logic [1:0]
  {
    PLY_IDLE  = 2'b00,
    PLY_TONE  = 2'b01,
    PLY_PAUSE = 2'b10
  } mnp_ply_e;

endpackage : mnp_pkg

// *** design/mnp_melody_note_player.sv ***
/*
  Melody note player with its serial register port and pin routing.
  Assumes the two-wire bus pins and the touch interrupt request are
  synchronous to clock_in; the pad logic resolves the open-drain wire.
*/
`timescale 1ns/1ps

// Overview of operation
// - A note is four bytes: scale, tone, width, pause
// - Timing fields are 0..255 in 4 ms units
// - Note play time is tone plus pause
// - Scale indexes 0..59, one semitone apart
// - Tone is tone clock over per-index divisor
// - Partial note at transaction end is dropped
// - Bytes arriving while buffer full are dropped
// - Buffer holds ten complete notes
// - Writing 0xFF as the scale byte stops tone, empties buffer
// - Melody register read returns free slots
// - Host sets pointer, then reads with 0x79
// - Low tone route bits drive key pins
// - High tone route bit drives extra pin
// - Power route bits drive melody power control
// - Interrupt route bits make pins interrupt outputs
// - Shutdown bit halts playback, keeps registers
module mnp_melody_note_player #(
  parameter int UNIT_CYCLES = mnp_pkg::UNIT_CYCLES,
  parameter int TONE_PRE    = mnp_pkg::TONE_PRE_CYCLES,
  parameter int SLOTS       = mnp_pkg::NOTE_SLOTS
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // Two-wire serial register port
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Interrupt request from the touch logic, active high
  input  wire logic       irq_req_in,
  // Key pins and extra pin
  output logic [7:0]      key_out,
  output logic [7:0]      key_oe_out,
  output logic            extra_out,
  output logic            extra_oe_out
);

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  mnp_pkg::mnp_bus_e bus_q;
  logic [3:0]        bit_q;
  logic [7:0]        shift_q;
  logic              scl_q;
  logic              sda_q;
  logic              first_q;
  logic              sda_oe_q;
  logic [7:0]        rdata;
  logic              rise;
  logic              fall;
  logic              start;
  logic              stop;
  logic              byte_wr;
  logic              rd_load;

  // Bus conditions from the previous pin samples
  assign rise    = scl_in & ~scl_q;
  assign fall    = ~scl_in & scl_q;
  assign start   = scl_in & scl_q & sda_q & ~sda_in;
  assign stop    = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_wr = fall && bit_q == 4'h7 && bus_q == mnp_pkg::BUS_WR;
  assign rd_load = fall && bit_q == 4'h8 && bus_q == mnp_pkg::BUS_RD;

  // Previous pin samples
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Slave sequencer; bits counted on falling clock edges, 8 is the ack slot
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      bus_q    <= mnp_pkg::BUS_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      sda_oe_q <= 1'b0;
      first_q  <= 1'b0;
    end
    else if (start)
    begin
      bus_q    <= mnp_pkg::BUS_ADDR;
      bit_q    <= 4'hF;                        // Clock fall after start is no bit
      sda_oe_q <= 1'b0;
      first_q  <= 1'b1;
    end
    else if (stop)
    begin
      bus_q    <= mnp_pkg::BUS_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (bus_q != mnp_pkg::BUS_IDLE)
    begin
      if (rise && bit_q < 4'h8 && bus_q != mnp_pkg::BUS_RD)
        shift_q <= {shift_q[6:0], sda_in};
      else if (rise && bit_q == 4'h8 && bus_q == mnp_pkg::BUS_RD && sda_in)
      begin
        bus_q <= mnp_pkg::BUS_IDLE;            // Master nack ends the read
      end
      if (fall)
      begin
        if (bit_q == 4'h7)
        begin
          bit_q <= 4'h8;
          if (bus_q == mnp_pkg::BUS_ADDR)
          begin
            // Only our address is acknowledged; others leave the bus alone
            if (shift_q[7:1] == mnp_pkg::DEV_ADDR)
            begin
              sda_oe_q <= 1'b1;
              bus_q    <= shift_q[0] ? mnp_pkg::BUS_RD : mnp_pkg::BUS_WR;
            end
            else
              bus_q <= mnp_pkg::BUS_IDLE;
          end
          else if (bus_q == mnp_pkg::BUS_WR)
          begin
            sda_oe_q <= 1'b1;
            first_q  <= 1'b0;
          end
          else
            sda_oe_q <= 1'b0;                  // Release for master ack
        end
        else if (bit_q == 4'h8)
        begin
          bit_q <= 4'h0;
          if (bus_q == mnp_pkg::BUS_RD)
          begin
            shift_q  <= rdata;
            sda_oe_q <= ~rdata[7];
          end
          else
            sda_oe_q <= 1'b0;
        end
        else
        begin
          bit_q <= bit_q + 4'h1;
          if (bus_q == mnp_pkg::BUS_RD)
          begin
            shift_q  <= {shift_q[6:0], 1'b0};
            sda_oe_q <= ~shift_q[6];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ptr_q;
  logic [7:0] config_q;
  logic [7:0] tone_pin_lo_q;
  logic       tone_pin_hi_q;
  logic [7:0] tone_pow_lo_q;
  logic       tone_pow_hi_q;
  logic [7:0] irq_pin_lo_q;
  logic       irq_pin_hi_q;
  logic       mel_wr;
  logic       shutdown;
  logic [3:0] cnt_q;

  assign mel_wr   = byte_wr && !first_q && ptr_q == mnp_pkg::OFF_MELODY;
  assign shutdown = config_q[mnp_pkg::SHUTDOWN_BIT];

  // Pointer and plain registers; the melody port does not auto-increment
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      ptr_q         <= 8'h00;
      config_q      <= mnp_pkg::RST_CONFIG;
      tone_pin_lo_q <= mnp_pkg::RST_TONE_PIN_LO;
      tone_pin_hi_q <= mnp_pkg::RST_TONE_PIN_HI;
      tone_pow_lo_q <= mnp_pkg::RST_TONE_POW_LO;
      tone_pow_hi_q <= mnp_pkg::RST_TONE_POW_HI;
      irq_pin_lo_q  <= mnp_pkg::RST_IRQ_PIN_LO;
      irq_pin_hi_q  <= mnp_pkg::RST_IRQ_PIN_HI;
    end
    else if (byte_wr && first_q)
      ptr_q <= shift_q;
    else if (byte_wr || rd_load)
    begin
      if (ptr_q != mnp_pkg::OFF_MELODY)
        ptr_q <= ptr_q + 8'h01;
      if (byte_wr)
      begin
        case (ptr_q)
          mnp_pkg::OFF_CONFIG:      config_q      <= shift_q;
          mnp_pkg::OFF_TONE_PIN_LO: tone_pin_lo_q <= shift_q;
          mnp_pkg::OFF_TONE_PIN_HI: tone_pin_hi_q <= shift_q[0];
          mnp_pkg::OFF_TONE_POW_LO: tone_pow_lo_q <= shift_q;
          mnp_pkg::OFF_TONE_POW_HI: tone_pow_hi_q <= shift_q[0];
          mnp_pkg::OFF_IRQ_PIN_LO:  irq_pin_lo_q  <= shift_q;
          mnp_pkg::OFF_IRQ_PIN_HI:  irq_pin_hi_q  <= shift_q[0];
          default:                  ;
        endcase
      end
    end
  end

  // Read data; unmapped offsets read zero
  always_comb
  begin
    case (ptr_q)
      mnp_pkg::OFF_CONFIG:      rdata = config_q;
      mnp_pkg::OFF_MELODY:      rdata = 8'(SLOTS) - {4'h0, cnt_q};
      mnp_pkg::OFF_TONE_PIN_LO: rdata = tone_pin_lo_q;
      mnp_pkg::OFF_TONE_PIN_HI: rdata = {7'h00, tone_pin_hi_q};
      mnp_pkg::OFF_TONE_POW_LO: rdata = tone_pow_lo_q;
      mnp_pkg::OFF_TONE_POW_HI: rdata = {7'h00, tone_pow_hi_q};
      mnp_pkg::OFF_IRQ_PIN_LO:  rdata = irq_pin_lo_q;
      mnp_pkg::OFF_IRQ_PIN_HI:  rdata = {7'h00, irq_pin_hi_q};
      default:                  rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Note assembly and buffer
  // ****************************************************************
  logic [1:0]  idx_q;
  logic [23:0] part_q;
  logic [31:0] mem_q [SLOTS];
  logic [3:0]  wp_q;
  logic [3:0]  rp_q;
  logic        clear;
  logic        push;
  logic        pop;

  // 0xFF only counts as a command in the scale byte position
  assign clear = mel_wr && idx_q == 2'd0 && shift_q == mnp_pkg::MELODY_CLEAR;
  assign push  = mel_wr && idx_q == 2'd3 && cnt_q < 4'(SLOTS);

  // Byte position within the note; any new transaction drops a partial note
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      idx_q  <= 2'd0;
      part_q <= 24'h00_0000;
    end
    else if (start || stop)
      idx_q <= 2'd0;
    else if (mel_wr && !clear)
    begin
      idx_q  <= idx_q + 2'd1;
      part_q <= {part_q[15:0], shift_q};
    end
  end

  // Circular note store
  always_ff @(posedge clock_in)
  begin
    if (push)
      mem_q[wp_q] <= {part_q, shift_q};
  end

  // Pointers and fill count
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || clear)
    begin
      wp_q  <= 4'h0;
      rp_q  <= 4'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == 4'(SLOTS - 1)) ? 4'h0 : wp_q + 4'h1;
      if (pop)
        rp_q <= (rp_q == 4'(SLOTS - 1)) ? 4'h0 : rp_q + 4'h1;
      if (push && !pop)
        cnt_q <= cnt_q + 4'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  // ****************************************************************
  // Player
  // ****************************************************************
  mnp_pkg::mnp_ply_e ply_q;
  logic [31:0]       note_q;
  logic [19:0]       unit_q;
  logic [7:0]        time_q;
  logic [8:0]        pre_q;
  logic [11:0]       half_q;
  logic [11:0]       div;
  logic              tone_q;
  logic              pow_q;
  logic              unit_end;
  logic              tick;

  assign pop      = ply_q == mnp_pkg::PLY_IDLE && cnt_q != 4'h0 && !shutdown && !clear;
  assign unit_end = unit_q == 20'(UNIT_CYCLES - 1);
  assign tick     = pre_q == 9'(TONE_PRE - 1);
  // Out-of-range scale indexes play as a rest
  assign div      = (note_q[31:24] < 8'(mnp_pkg::SCALE_COUNT)) ?
                    mnp_pkg::SCALE_DIV[note_q[29:24]] : 12'h000;

  // Note sequencer; shutdown freezes it where it stands
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || clear)
    begin
      ply_q  <= mnp_pkg::PLY_IDLE;
      note_q <= 32'h0000_0000;
      unit_q <= 20'h0_0000;
      time_q <= 8'h00;
    end
    else if (!shutdown)
    begin
      unit_q <= unit_end ? 20'h0_0000 : unit_q + 20'h0_0001;
      case (ply_q)
        mnp_pkg::PLY_IDLE:
        begin
          if (pop)
          begin
            note_q <= mem_q[rp_q];
            ply_q  <= mnp_pkg::PLY_TONE;
            unit_q <= 20'h0_0000;
            time_q <= 8'h00;
          end
        end
        mnp_pkg::PLY_TONE:
        begin
          if (time_q == note_q[23:16])
          begin
            ply_q  <= mnp_pkg::PLY_PAUSE;
            time_q <= 8'h00;
          end
          else if (unit_end)
            time_q <= time_q + 8'h01;
        end
        mnp_pkg::PLY_PAUSE:
        begin
          if (time_q == note_q[7:0])
            ply_q <= mnp_pkg::PLY_IDLE;
          else if (unit_end)
            time_q <= time_q + 8'h01;
        end
        default: ply_q <= mnp_pkg::PLY_IDLE;
      endcase
    end
  end

  // Tone clock prescaler and square wave at tone clock over divisor
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || ply_q != mnp_pkg::PLY_TONE || shutdown)
    begin
      pre_q  <= 9'h000;
      half_q <= 12'h000;
      tone_q <= 1'b0;
    end
    else
    begin
      pre_q <= tick ? 9'h000 : pre_q + 9'h001;
      if (tick)
        half_q <= (half_q >= div - 12'h001) ? 12'h000 : half_q + 12'h001;
      tone_q <= div != 12'h000 && half_q < {1'b0, div[11:1]};
    end
  end

  // Power stays on through the tone and for the width time after it
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || clear || shutdown)
      pow_q <= 1'b0;
    else
      pow_q <= ply_q == mnp_pkg::PLY_TONE ||
               (ply_q == mnp_pkg::PLY_PAUSE && time_q < note_q[15:8]);
  end

  // ****************************************************************
  // Pin routing; tone beats power beats interrupt on a shared pin
  // ****************************************************************
  logic [8:0] r_tone;
  logic [8:0] r_pow;
  logic [8:0] r_irq;
  logic [8:0] pin_q;
  logic [8:0] pin_oe_q;

  assign r_tone = {tone_pin_hi_q, tone_pin_lo_q};
  assign r_pow  = {tone_pow_hi_q, tone_pow_lo_q};
  assign r_irq  = {irq_pin_hi_q, irq_pin_lo_q};

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      pin_q    <= 9'h000;
      pin_oe_q <= 9'h000;
    end
    else
    begin
      for (int i = 0; i < 9; i++)
      begin
        if (r_tone[i])
        begin
          pin_q[i]    <= tone_q;
          pin_oe_q[i] <= 1'b1;
        end
        else if (r_pow[i])
        begin
          pin_q[i]    <= pow_q;
          pin_oe_q[i] <= 1'b1;
        end
        else
        begin
          pin_q[i]    <= 1'b0;                 // Open drain, active low
          pin_oe_q[i] <= r_irq[i] & irq_req_in;
        end
      end
    end
  end

  assign key_out      = pin_q[7:0];
  assign key_oe_out   = pin_oe_q[7:0];
  assign extra_out    = pin_q[8];
  assign extra_oe_out = pin_oe_q[8];
  assign sda_out      = 1'b0;                  // Open drain only pulls low
  assign sda_oe_out   = sda_oe_q;

endmodule : mnp_melody_note_player

// *** verif/mnp_melody_note_player_asserts.sv ***
/*
  Port checker for the melody note player, bound to its top module.
  Assumes the bench never makes key 2 a power pin.
*/
`timescale 1ns/1ps
module mnp_melody_note_player_asserts #(
  parameter int UNIT_CYCLES = 1,
  parameter int TONE_PRE    = 1,
  parameter int SLOTS       = 1
) (
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       nrst_in,
  // Serial port
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  // Pins
  input wire logic       irq_req_in,
  input wire logic [7:0] key_out,
  input wire logic [7:0] key_oe_out,
  input wire logic       extra_out,
  input wire logic       extra_oe_out
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  localparam int HALF_MAX = (2273 * TONE_PRE + 1) / 2;  // Slowest note
  logic [15:0] hi_q;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  // High run on key 2; a stuck tone would grow past any half period
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || !key_out[2] || !key_oe_out[2])
      hi_q <= 16'h0000;
    else
      hi_q <= hi_q + 16'h0001;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_sda_low_only;
    sda_out == 1'b0;
  endproperty
  a_sda_low_only : assert property (p_sda_low_only)
    else $error("data pin driven high");

  property p_sda_moves_low;
    $changed(sda_oe_out) |-> !scl_in || $fell(sda_oe_out);
  endproperty
  a_sda_moves_low : assert property (p_sda_moves_low)
    else $error("data pull changed in clock high");

  property p_sda_released;
    $rose(sda_oe_out) |-> ##[1:200] !sda_oe_out;
  endproperty
  a_sda_released : assert property (p_sda_released)
    else $error("data pull never released");

  property p_key_open;
    (key_out & ~key_oe_out) == 8'h00;
  endproperty
  a_key_open : assert property (p_key_open)
    else $error("key high while undriven");

  property p_extra_open;
    extra_out |-> extra_oe_out;
  endproperty
  a_extra_open : assert property (p_extra_open)
    else $error("extra high while undriven");

  property p_route_reset;
    $rose(nrst_in) |=> key_oe_out == 8'h04 && extra_oe_out && key_out == 8'h00 && !extra_out;
  endproperty
  a_route_reset : assert property (p_route_reset)
    else $error("pin routing not at reset state");

  property p_tone_half;
    hi_q <= HALF_MAX;
  endproperty
  a_tone_half : assert property (p_tone_half)
    else $error("tone high longer than slowest half period");

  property p_power_in_tone;
    key_out[2] && $past(key_out[2]) && key_oe_out[2] && extra_oe_out |-> extra_out;
  endproperty
  a_power_in_tone : assert property (p_power_in_tone)
    else $error("power low while tone plays");

endmodule : mnp_melody_note_player_asserts

bind mnp_melody_note_player mnp_melody_note_player_asserts #(
  .UNIT_CYCLES (UNIT_CYCLES),
  .TONE_PRE    (TONE_PRE),
  .SLOTS       (SLOTS)
) u_asserts (
  .clock_in, .nrst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .irq_req_in, .key_out, .key_oe_out, .extra_out, .extra_oe_out
);

// *** verif/mnp_host_model.sv ***
/*
  Host bus master model for the two-wire register port.
  Assumes the bench resolves the pulled-up data wire and feeds it back.
*/
`timescale 1ns/1ps
module mnp_host_model (
  // Clock
  input  wire logic clock_in,
  // Bus wires; a high pull output pulls data low
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  // ****************************************************************
  // Wire phases
  // ****************************************************************
  logic s;

  // Idle bus: both wires released
  initial
  begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  // One phase: set wires, hold four clocks, sample data at its end.
  // Four clocks keep every phase above the two-clock minimum.
  task automatic step(input logic c, input logic p);
    scl_out      = c;
    sda_pull_out = p;
    repeat (4) @(posedge clock_in);
    #1;
    s = sda_in;
  endtask : step

  // Data falls while the clock is high
  task automatic start;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start

  // Data rises while the clock is high
  task automatic stop;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop

  // Top bit first, then a ninth clock for the answer
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, ~b[i]);
      step(1'b1, ~b[i]);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    ack = ~s;
  endtask : put

  // Read eight bits, then answer; nack ends the read
  task automatic get(output logic [7:0] b, input logic nack);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      b[i] = s;
    end
    step(1'b0, ~nack);
    step(1'b1, ~nack);
  endtask : get

endmodule : mnp_host_model

// *** verif/mnp_melody_note_player_test.sv ***
/*
  Self-checking bench for the melody note player.
  Assumes the host model drives the bus; the data wire has a pull-up.
*/
`timescale 1ns/1ps
module mnp_melody_note_player_test;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int UNIT = 500;
  logic        clock_in, nrst_in, irq_req_in, scl, pull, k;
  logic        sda_out, sda_oe_out, extra_out, extra_oe_out;
  logic [7:0]  key_out, key_oe_out;
  logic [15:0] n;
  int          miscompares, samples_checked;
  wire         sda = ~(pull | sda_oe_out);  // Released wire reads high
  logic [15:0] rst_tab [9] = '{16'hF00A, 16'hF804, 16'hF900, 16'hFA00, 16'hFB01,
                               16'hFC00, 16'hFD00, 16'h0000, 16'h5000};

  // Free-running 250 MHz clock
  initial clock_in = 1'b0;
  always #2 clock_in = ~clock_in;

  mnp_melody_note_player #(.UNIT_CYCLES(UNIT), .TONE_PRE(2), .SLOTS(10)) u_dut (
    .clock_in     (clock_in),
    .nrst_in      (nrst_in),
    .scl_in       (scl),
    .sda_in       (sda),
    .sda_out      (sda_out),
    .sda_oe_out   (sda_oe_out),
    .irq_req_in   (irq_req_in),
    .key_out      (key_out),
    .key_oe_out   (key_oe_out),
    .extra_out    (extra_out),
    .extra_oe_out (extra_oe_out)
  );
  mnp_host_model u_host (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic timeout;
    miscompares++;
    end_of_test();
  endtask : timeout

  // Watched pin: 0 key 2 tone, 1 extra pin, 2 key 0 power
  function automatic logic pin(input int s);
    return s == 0 ? key_out[2] : (s == 1 ? extra_out : key_out[0]);
  endfunction : pin

  task automatic wait_for(input int s, input logic v);
    int t;
    t = 0;
    while (pin(s) !== v)
    begin
      tick(1);
      t++;
      if (t > 20000)
        timeout();
    end
  endtask : wait_for

  task automatic count(input int s, input logic v);
    n = 16'h0000;
    while (pin(s) === v)
    begin
      tick(1);
      n++;
      if (n > 16'd20000)
        timeout();
    end
  endtask : count

  // Small slack covers the latch and pop latency
  task automatic near(input int e);
    check(n >= e && n <= e + 3, 1'b1);
  endtask : near

  task automatic pins(input logic [17:0] e);
    check({key_oe_out, extra_oe_out, key_out, extra_out}, e);
  endtask : pins

  task automatic open_wr(input logic [7:0] a);
    logic ak;
    u_host.start();
    u_host.put(8'h78, ak);
    check(ak, 1'b1);
    u_host.put(a, ak);
    check(ak, 1'b1);
  endtask : open_wr

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    open_wr(a);
    u_host.put(d, k);
    u_host.stop();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    open_wr(a);
    u_host.start();
    u_host.put(8'h79, k);
    check(k, 1'b1);
    u_host.get(d, 1'b1);
    u_host.stop();
    check(d, e);
  endtask : reg_rd

  // Note bytes cycle scale, tone, width, pause; nb may cut a note short
  task automatic notes(input int nb, input logic [31:0] nt);
    open_wr(8'hF0);
    for (int i = 0; i < nb; i++)
    begin
      u_host.put(nt[8 * (3 - i % 4) +: 8], k);
      check(k, 1'b1);
    end
    u_host.stop();
  endtask : notes

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    miscompares     = 0;
    samples_checked = 0;
    nrst_in         = 1'b0;
    irq_req_in      = 1'b0;
    tick(16);
    nrst_in = 1'b1;
    tick(2);
    pins({8'h04, 1'b1, 8'h00, 1'b0});
    foreach (rst_tab[i])
      reg_rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    // Foreign address is not answered
    u_host.start();
    u_host.put(8'h7A, k);
    check(k, 1'b0);
    u_host.stop();
    notes(3, 32'h0C01_0101);
    reg_rd(8'hF0, 8'h0A);
    // Twelve long notes: one plays, ten wait, the last is dropped
    reg_wr(8'hF9, 8'h01);
    notes(48, 32'h0CFF_00FF);
    reg_rd(8'hF0, 8'h00);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    count(0, 1'b1);
    near(1136);
    check({extra_out, extra_oe_out}, {key_out[2], 1'b1});
    notes(1, 32'hFF00_0000);
    pins({8'h04, 1'b1, 8'h00, 1'b0});
    reg_rd(8'hF0, 8'h0A);
    reg_wr(8'hF9, 8'h00);
    // Two notes in order; power holds into the pause for the width time
    reg_wr(8'hFA, 8'h01);
    notes(4, 32'h3B04_0206);
    notes(4, 32'h2402_0000);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    // Odd divisor 75: high for 37 tone clocks, low for 38
    count(0, 1'b1);
    near(74);
    count(0, 1'b0);
    near(76);
    wait_for(2, 1'b0);
    count(2, 1'b0);
    near(4 * UNIT);
    count(2, 1'b1);
    near(2 * UNIT);
    tick(4 * UNIT);
    pins({8'h05, 1'b1, 8'h00, 1'b0});
    // Shutdown freezes playback but keeps registers
    reg_wr(8'h00, 8'h01);
    notes(4, 32'h0C01_0001);
    tick(UNIT);
    pins({8'h05, 1'b1, 8'h00, 1'b0});
    reg_rd(8'hFA, 8'h01);
    reg_rd(8'h00, 8'h01);
    reg_wr(8'h00, 8'h00);
    wait_for(0, 1'b1);
    tick(3 * UNIT);
    // Interrupt routing on key 4 and the extra pin
    reg_wr(8'hFC, 8'h10);
    reg_wr(8'hFD, 8'h01);
    reg_wr(8'hFB, 8'h00);
    irq_req_in = 1'b1;
    tick(3);
    pins({8'h15, 1'b1, 8'h00, 1'b0});
    irq_req_in = 1'b0;
    tick(3);
    pins({8'h05, 1'b0, 8'h00, 1'b0});
    // Reset in mid-run restores the routing
    nrst_in = 1'b0;
    tick(2);
    pins(18'h0_0000);
    nrst_in = 1'b1;
    tick(2);
    pins({8'h04, 1'b1, 8'h00, 1'b0});
    end_of_test();
  end

endmodule : mnp_melody_note_player_test
